// [hw/flash_status_pkg.sv]
package flash_status_pkg;

  // Clock and reset pulse timing.
  localparam int unsigned CLOCK_PERIOD_NS = 50;
  localparam int unsigned RESET_PULSE_MIN_NS = 100;
  localparam int unsigned RESET_PULSE_CYCLES = (RESET_PULSE_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int unsigned PROGRAM_RESET_MIN_NS = 5000;

  // Instruction codes.
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] OP_STATUS_WRITE_ENABLE = 8'h50;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAUSE_ENABLE = 8'haa;
  localparam logic [7:0] OP_BYTE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_AUTO_INCREMENT = 8'had;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_BLOCK32_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK64_ERASE = 8'hd8;
  localparam logic [7:0] OP_CHIP_ERASE_A = 8'h60;
  localparam logic [7:0] OP_CHIP_ERASE_B = 8'hc7;

  // Frame lengths in serial bits, opcode included.
  localparam logic [5:0] BITS_OPCODE_ONLY = 6'h08;
  localparam logic [5:0] BITS_STATUS_WRITE = 6'h10;
  localparam logic [5:0] BITS_AAI_NEXT = 6'h18;
  localparam logic [5:0] BITS_ERASE = 6'h20;
  localparam logic [5:0] BITS_BYTE_PROGRAM = 6'h28;
  localparam logic [5:0] BITS_AAI_FIRST = 6'h30;

  // Status register field positions and power-up value.
  localparam int unsigned BIT_BUSY = 0;
  localparam int unsigned BIT_WRITE_LATCH = 1;
  localparam int unsigned BIT_LEVEL_LO = 2;
  localparam int unsigned BIT_LEVEL_HI = 5;
  localparam int unsigned BIT_AUTO_INCREMENT = 6;
  localparam int unsigned BIT_LOCK = 7;
  localparam logic [3:0] LEVEL_RESET = 4'h7;
  localparam logic [7:0] STATUS_RESET = 8'h1c;

  // Start of the protected range for each lower protection code.
  localparam logic [19:0] BASE_LEVEL_1 = 20'hf0000;
  localparam logic [19:0] BASE_LEVEL_2 = 20'he0000;
  localparam logic [19:0] BASE_LEVEL_3 = 20'hc0000;
  localparam logic [19:0] BASE_LEVEL_4 = 20'h80000;
  localparam logic [19:0] BASE_LEVEL_5 = 20'h00000;
  localparam logic [19:0] AAI_STEP = 20'h00002;

  typedef enum logic [2:0] {
    KIND_BYTE_PROGRAM = 3'h0,
    KIND_AAI_WORD = 3'h1,
    KIND_SECTOR_ERASE = 3'h2,
    KIND_BLOCK32_ERASE = 3'h3,
    KIND_BLOCK64_ERASE = 3'h4,
    KIND_CHIP_ERASE = 3'h5
  } op_kind_type;

  typedef struct packed {
    op_kind_type kind;
    logic [23:0] addr;
    logic [15:0] data;
  } op_request_type;

  typedef enum logic [2:0] {
    LINK_STANDBY = 3'b001,
    LINK_SHIFTING = 3'b010,
    LINK_HELD = 3'b100
  } link_state_type;

endpackage : flash_status_pkg

// [hw/pin_sync.sv]
`timescale 1ns/1ns
module pin_sync #(
  parameter int unsigned WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Asynchronous pins and their synchronised copies.
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync_out
);

  logic [WIDTH-1:0] first_stage;

  if (WIDTH < 1) begin : g_width_check
    $error("pin_sync needs at least one bit");
  end

  // The first stage feeds only the second stage.
  always_ff @(posedge mclk) begin
    if (reset) begin
      first_stage <= RESET_VALUE;
      pin_sync_out <= RESET_VALUE;
    end else begin
      first_stage <= pin_async;
      pin_sync_out <= first_stage;
    end
  end

endmodule : pin_sync

// [hw/protect_decode.sv]
`timescale 1ns/1ns
module protect_decode #(
  parameter int unsigned ADDR_BITS = 20
) (
  // Lower three protection level bits and the address to check.
  input wire logic [2:0] level,
  input wire logic [ADDR_BITS-1:0] addr,
  // High when the address lies in the protected range.
  output logic protected_hit
);

  if (ADDR_BITS != 20) begin : g_addr_check
    $error("protect_decode range bases assume a 20-bit array address");
  end

  always_comb begin
    unique case (level)
      3'h0: protected_hit = 1'b0; // see R20
      3'h1: protected_hit = addr >= flash_status_pkg::BASE_LEVEL_1; // see R20
      3'h2: protected_hit = addr >= flash_status_pkg::BASE_LEVEL_2; // see R20
      3'h3: protected_hit = addr >= flash_status_pkg::BASE_LEVEL_3; // see R20
      3'h4: protected_hit = addr >= flash_status_pkg::BASE_LEVEL_4; // see R20
      3'h5: protected_hit = addr >= flash_status_pkg::BASE_LEVEL_5; // see R20
      // Undefined codes lock the whole array so no write slips through.
      default: protected_hit = 1'b1; // see R21
    endcase
  end

endmodule : protect_decode

// [hw/flash_status_protect_hold.sv]
// Summary of operation
// R1: Host holds reset low over 5 us when resetting during program or erase.
// R2: Once hold function is chosen, the shared pin stays hold until power-up reset.
// R3: Host keeps chip select low to enter hold; no hold while deselected.
// R4: Hold begins when hold is low with serial clock low, else waits for clock low.
// R5: Hold ends when hold is high with serial clock low, else waits for clock low.
// R6: While held, keep bit position, float serial output, ignore clock and input.
// R7: Chip select high during hold abandons the sequence and returns to standby.
// R8: Host raises hold with chip select low to resume; hold lasts while pin low.
// R9: Status write refused when protect pin low and lock bit set.
// R10: Protect pin low with lock set freezes lock and level bits.
// R11: Status layout: busy 0, latch 1, levels 2-5, auto-increment 6, lock 7.
// R12: Busy reads 1 during internal program or erase, else 0.
// R13: Host only reads status while busy.
// R14: Program and erase commands refused while write latch is 0.
// R15: Write latch clears on resets, disable, program, erase, status write, increment end.
// R16: Auto-increment flag reads 1 in increment mode, 0 in single-byte mode.
// R17: Power-up status has levels 0-2 set and every other bit clear.
// R18: Chip erase runs only with all four level bits zero.
// R19: Program or erase into the protected range is refused.
// R20: Lower level codes select none, top 1/16, 1/8, 1/4, 1/2 or whole array.
// R21: Undefined lower codes protect the whole array.
// R22: Opcode aa switches the shared pin to hold function.
// R23: Host enables writes before a status write, program or erase.
// R24: A pin reset returns the status register to power-up values.
`timescale 1ns/1ns
module flash_status_protect_hold #(
  parameter int unsigned RESET_PULSE_CYCLES = flash_status_pkg::RESET_PULSE_CYCLES
) (
  // Clock and power-up reset.
  input wire logic mclk,
  input wire logic reset,
  // Serial pins.
  input wire logic sck,
  input wire logic ce_n,
  input wire logic si,
  output logic so,
  output logic so_oe,
  // Protection and shared reset or hold pin.
  input wire logic wp_n,
  input wire logic rst_hold_n,
  // Array datapath handshake.
  output flash_status_pkg::op_request_type op_request,
  output logic op_valid,
  input wire logic op_done,
  output logic array_abort,
  // Observation.
  output logic [7:0] status_and_protection,
  output logic hold_active,
  output logic hold_mode
);

  if (RESET_PULSE_CYCLES < 1 || RESET_PULSE_CYCLES > 255) begin : g_pulse_check
    $error("RESET_PULSE_CYCLES must lie in 1..255");
  end

  localparam logic [7:0] PULSE_LIMIT = 8'(RESET_PULSE_CYCLES);
  logic [4:0] pins_sync;
  logic sck_s;
  logic ce_n_s;
  logic si_s;
  logic wp_n_s;
  logic rst_hold_n_s;
  logic sck_d;
  logic sck_rise;
  logic sck_fall;
  flash_status_pkg::link_state_type state;
  logic [7:0] pulse_count;
  logic pin_reset;
  logic local_reset;
  logic [5:0] bit_count;
  logic [47:0] frame;
  logic [7:0] opcode;
  logic reading;
  logic [7:0] out_shift;
  logic [2:0] out_bits;
  logic busy;
  logic write_latch;
  logic [3:0] protect_level;
  logic auto_increment_program;
  logic protect_lock;
  logic status_write_armed;
  logic clear_on_done;
  logic [23:0] aai_addr;
  logic exec;
  logic [23:0] target_addr;
  logic [20:0] after_sum;
  logic target_protected;
  logic after_protected;
  logic accept;
  logic next_last;
  flash_status_pkg::op_request_type next_request;

  pin_sync #(
    .WIDTH(5),
    .RESET_VALUE(5'h1e)
  ) u_pin_sync (
    .mclk(mclk),
    .reset(reset),
    .pin_async({rst_hold_n, wp_n, si, ce_n, sck}),
    .pin_sync_out(pins_sync)
  );
  assign sck_s = pins_sync[0];
  assign ce_n_s = pins_sync[1];
  assign si_s = pins_sync[2];
  assign wp_n_s = pins_sync[3];
  assign rst_hold_n_s = pins_sync[4];
  // Hold function persists until the power-up reset only.
  always_ff @(posedge mclk) begin
    if (reset) begin
      hold_mode <= 1'b0; // see R2
    end else if (exec && !busy && opcode == flash_status_pkg::OP_PAUSE_ENABLE
                 && bit_count == flash_status_pkg::BITS_OPCODE_ONLY) begin
      hold_mode <= 1'b1; // see R22
    end
  end

  // Reset function of the shared pin: a low level must last the minimum pulse width.
  always_ff @(posedge mclk) begin
    if (reset || hold_mode || rst_hold_n_s) begin
      pulse_count <= 8'h00;
    end else if (pulse_count != PULSE_LIMIT) begin
      pulse_count <= pulse_count + 8'h01;
    end
  end

  assign pin_reset = pulse_count == PULSE_LIMIT;
  assign local_reset = reset || pin_reset;
  assign array_abort = pin_reset;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sck_d <= 1'b0;
    end else begin
      sck_d <= sck_s;
    end
  end

  // Clock edges only count while shifting, so a held sequence keeps its position.
  assign sck_rise = state == flash_status_pkg::LINK_SHIFTING && sck_s && !sck_d; // see R6
  assign sck_fall = state == flash_status_pkg::LINK_SHIFTING && !sck_s && sck_d; // see R6
  always_ff @(posedge mclk) begin
    if (local_reset) begin
      state <= flash_status_pkg::LINK_STANDBY;
    end else begin
      unique case (state)
        flash_status_pkg::LINK_STANDBY: begin
          if (!ce_n_s) begin
            state <= flash_status_pkg::LINK_SHIFTING;
          end
        end
        flash_status_pkg::LINK_SHIFTING: begin
          if (ce_n_s) begin
            state <= flash_status_pkg::LINK_STANDBY; // see R3
          end else if (hold_mode && !rst_hold_n_s && !sck_s) begin
            state <= flash_status_pkg::LINK_HELD; // see R4
          end
        end
        flash_status_pkg::LINK_HELD: begin
          if (ce_n_s) begin
            state <= flash_status_pkg::LINK_STANDBY; // see R7
          end else if (rst_hold_n_s && !sck_s) begin
            state <= flash_status_pkg::LINK_SHIFTING; // see R5
          end
        end
      endcase
    end
  end

  assign hold_active = state == flash_status_pkg::LINK_HELD;
  // A frame executes only when chip select rises from the shifting state, never from hold.
  assign exec = state == flash_status_pkg::LINK_SHIFTING && ce_n_s; // see R7
  always_ff @(posedge mclk) begin
    if (local_reset || state == flash_status_pkg::LINK_STANDBY) begin
      bit_count <= 6'h00;
      frame <= 48'h0;
      opcode <= 8'h00;
      reading <= 1'b0;
    end else if (sck_rise) begin
      frame <= {frame[46:0], si_s};
      if (bit_count != 6'h3f) begin
        bit_count <= bit_count + 6'h01;
      end
      if (bit_count == 6'h07) begin
        opcode <= {frame[6:0], si_s};
        reading <= {frame[6:0], si_s} == flash_status_pkg::OP_READ_STATUS;
      end
    end
  end

  // Status is snapshotted at each byte boundary and shifted out on falling edges.
  always_ff @(posedge mclk) begin
    if (local_reset || !reading) begin
      out_shift <= 8'h00;
      out_bits <= 3'h0;
      so <= 1'b0;
    end else if (sck_fall) begin
      out_bits <= out_bits + 3'h1;
      if (out_bits == 3'h0) begin
        so <= status_and_protection[7];
        out_shift <= {status_and_protection[6:0], 1'b0};
      end else begin
        so <= out_shift[7];
        out_shift <= {out_shift[6:0], 1'b0};
      end
    end
  end

  assign so_oe = reading && state == flash_status_pkg::LINK_SHIFTING && !ce_n_s; // see R6
  always_comb begin
    unique case (opcode)
      flash_status_pkg::OP_BYTE_PROGRAM: target_addr = frame[31:8];
      flash_status_pkg::OP_AUTO_INCREMENT: begin
        if (auto_increment_program) begin
          target_addr = {aai_addr[23:20], aai_addr[19:0] + flash_status_pkg::AAI_STEP};
        end else begin
          target_addr = {frame[39:17], 1'b0};
        end
      end
      default: target_addr = frame[23:0];
    endcase
  end
  assign after_sum = {1'b0, target_addr[19:0]} + {1'b0, flash_status_pkg::AAI_STEP};
  protect_decode #(
    .ADDR_BITS(20)
  ) u_target_decode (
    .level(protect_level[2:0]),
    .addr(target_addr[19:0]),
    .protected_hit(target_protected)
  );

  protect_decode #(
    .ADDR_BITS(20)
  ) u_after_decode (
    .level(protect_level[2:0]),
    .addr(after_sum[19:0]),
    .protected_hit(after_protected)
  );

  always_comb begin
    accept = 1'b0;
    next_last = 1'b1;
    next_request = '{kind: flash_status_pkg::KIND_BYTE_PROGRAM, addr: target_addr, data: frame[15:0]};
    if (exec && !busy && write_latch && !target_protected) begin // see R14 see R19
      unique case (opcode)
        flash_status_pkg::OP_BYTE_PROGRAM: begin
          accept = bit_count == flash_status_pkg::BITS_BYTE_PROGRAM && !auto_increment_program;
          next_request.data = {8'h00, frame[7:0]};
        end
        flash_status_pkg::OP_SECTOR_ERASE: begin
          accept = bit_count == flash_status_pkg::BITS_ERASE && !auto_increment_program;
          next_request.kind = flash_status_pkg::KIND_SECTOR_ERASE;
        end
        flash_status_pkg::OP_BLOCK32_ERASE: begin
          accept = bit_count == flash_status_pkg::BITS_ERASE && !auto_increment_program;
          next_request.kind = flash_status_pkg::KIND_BLOCK32_ERASE;
        end
        flash_status_pkg::OP_BLOCK64_ERASE: begin
          accept = bit_count == flash_status_pkg::BITS_ERASE && !auto_increment_program;
          next_request.kind = flash_status_pkg::KIND_BLOCK64_ERASE;
        end
        flash_status_pkg::OP_AUTO_INCREMENT: begin
          accept = auto_increment_program ? bit_count == flash_status_pkg::BITS_AAI_NEXT
                                          : bit_count == flash_status_pkg::BITS_AAI_FIRST;
          next_request.kind = flash_status_pkg::KIND_AAI_WORD;
          next_last = after_sum[20] || after_protected; // see R15
        end
        default: accept = 1'b0;
      endcase
    end
    if (exec && !busy && write_latch && !auto_increment_program && bit_count == flash_status_pkg::BITS_OPCODE_ONLY
        && (opcode == flash_status_pkg::OP_CHIP_ERASE_A || opcode == flash_status_pkg::OP_CHIP_ERASE_B)
        && protect_level == 4'h0) begin // see R18
      accept = 1'b1;
      next_request.kind = flash_status_pkg::KIND_CHIP_ERASE;
      next_request.addr = 24'h000000;
    end
  end

  always_ff @(posedge mclk) begin
    if (local_reset) begin
      op_valid <= 1'b0;
      op_request <= '{kind: flash_status_pkg::KIND_BYTE_PROGRAM, addr: 24'h000000, data: 16'h0000};
    end else begin
      op_valid <= accept;
      if (accept) begin
        op_request <= next_request;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (local_reset) begin
      busy <= 1'b0; // see R17 see R24
      write_latch <= 1'b0; // see R15
      protect_level <= flash_status_pkg::LEVEL_RESET; // see R17
      auto_increment_program <= 1'b0; // see R16
      protect_lock <= 1'b0;
      status_write_armed <= 1'b0;
      clear_on_done <= 1'b0;
      aai_addr <= 24'h000000;
    end else begin
      if (busy && op_done) begin
        busy <= 1'b0; // see R12
        if (clear_on_done) begin
          write_latch <= 1'b0; // see R15
          auto_increment_program <= 1'b0; // see R16
        end
      end
      if (accept) begin
        busy <= 1'b1; // see R12
        clear_on_done <= opcode != flash_status_pkg::OP_AUTO_INCREMENT || next_last;
        if (opcode == flash_status_pkg::OP_AUTO_INCREMENT) begin
          auto_increment_program <= 1'b1; // see R16
          aai_addr <= target_addr;
        end
      end else if (exec && !busy) begin
        unique case (opcode)
          flash_status_pkg::OP_WRITE_ENABLE: begin
            if (bit_count == flash_status_pkg::BITS_OPCODE_ONLY) begin
              write_latch <= 1'b1;
            end
          end
          flash_status_pkg::OP_WRITE_DISABLE: begin
            if (bit_count == flash_status_pkg::BITS_OPCODE_ONLY) begin
              write_latch <= 1'b0; // see R15
              auto_increment_program <= 1'b0;
            end
          end
          flash_status_pkg::OP_STATUS_WRITE_ENABLE: begin
            if (bit_count == flash_status_pkg::BITS_OPCODE_ONLY) begin
              status_write_armed <= 1'b1;
            end
          end
          flash_status_pkg::OP_STATUS_WRITE: begin
            if (bit_count == flash_status_pkg::BITS_STATUS_WRITE) begin
              if ((write_latch || status_write_armed) && !(!wp_n_s && protect_lock)) begin // see R9 see R10
                protect_level <= frame[flash_status_pkg::BIT_LEVEL_HI:flash_status_pkg::BIT_LEVEL_LO];
                protect_lock <= frame[flash_status_pkg::BIT_LOCK];
              end
              write_latch <= 1'b0; // see R15
              status_write_armed <= 1'b0;
            end
          end
          flash_status_pkg::OP_AUTO_INCREMENT: begin
            // A word that would land in protected space ends the mode at once.
            if (auto_increment_program && bit_count == flash_status_pkg::BITS_AAI_NEXT) begin
              auto_increment_program <= 1'b0; // see R15
              write_latch <= 1'b0; // see R15
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
  always_comb begin
    status_and_protection = 8'h00;
    status_and_protection[flash_status_pkg::BIT_BUSY] = busy; // see R11 see R12
    status_and_protection[flash_status_pkg::BIT_WRITE_LATCH] = write_latch; // see R11
    status_and_protection[flash_status_pkg::BIT_LEVEL_HI:flash_status_pkg::BIT_LEVEL_LO] = protect_level; // see R11
    status_and_protection[flash_status_pkg::BIT_AUTO_INCREMENT] = auto_increment_program; // see R11 see R16
    status_and_protection[flash_status_pkg::BIT_LOCK] = protect_lock; // see R11
  end

endmodule : flash_status_protect_hold

// [tb/flash_status_monitor.sv]
`timescale 1ns/1ns
module flash_status_monitor (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // Pins.
  input wire logic ce_n,
  input wire logic so_oe,
  input wire logic wp_n,
  input wire logic rst_hold_n,
  // Array handshake and observation.
  input wire flash_status_pkg::op_request_type op_request,
  input wire logic op_valid,
  input wire logic op_done,
  input wire logic array_abort,
  input wire logic [7:0] status_and_protection,
  input wire logic hold_active,
  input wire logic hold_mode
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);
  wire logic [7:0] st = status_and_protection;
  busy_on_accept_a: assert property (op_valid |-> ##[0:1] st[0])
    else $error("busy not set after accept");
  done_clears_a: assert property (st[0] && op_done |=> !st[0] && (st[6] || !st[1]))
    else $error("done left busy or latch set");
  accept_needs_latch_a: assert property (op_valid |-> st[1])
    else $error("accept without write latch");
  chip_erase_gate_a: assert property (op_valid && op_request.kind == flash_status_pkg::KIND_CHIP_ERASE
    |-> st[5:2] == 4'h0) else $error("chip erase with protection set");
  full_protect_a: assert property (op_valid |-> st[4:2] < 3'h5)
    else $error("accept with whole array protected");
  hold_needs_mode_a: assert property (hold_active |-> hold_mode && !so_oe)
    else $error("hold without mode or output driven");
  mode_sticky_a: assert property (hold_mode |=> hold_mode && !array_abort)
    else $error("hold function lost");
  deselect_release_a: assert property (hold_active && ce_n |-> ##[1:6] !hold_active)
    else $error("hold kept after deselect");
  lock_freeze_a: assert property ((st[7] && !wp_n && rst_hold_n) [*4] |=> st[7] && $stable(st[5:2]))
    else $error("locked bits changed");
  pin_reset_a: assert property ((!rst_hold_n && !hold_mode) [*6]
    |-> array_abort && st == flash_status_pkg::STATUS_RESET) else $error("pin reset not applied");
  power_up_a: assert property ($fell(reset) |-> st == flash_status_pkg::STATUS_RESET && !hold_mode)
    else $error("wrong power-up state");
  cover property (op_valid);
  cover property ($rose(hold_active));
  cover property ($rose(array_abort));
endmodule : flash_status_monitor

bind flash_status_protect_hold flash_status_monitor i_flash_status_monitor (.mclk, .reset, .ce_n, .so_oe,
  .wp_n, .rst_hold_n, .op_request, .op_valid, .op_done, .array_abort, .status_and_protection, .hold_active,
  .hold_mode);

// [tb/spi_host_model.sv]
`timescale 1ns/1ns
module spi_host_model (
  // Clock.
  input wire logic mclk,
  // Serial pins.
  output logic sck,
  output logic ce_n,
  output logic si,
  input wire logic so,
  output logic hold_n
);
  logic [7:0] rx;
  initial begin
    sck = 1'b0;
    ce_n = 1'b1;
    si = 1'b0;
    hold_n = 1'b1;
  end
  // Mode 0, 400 ns period; the output bit is taken just before the falling edge,
  // since the device only updates it after it has seen that edge.
  task automatic shift(input logic [47:0] bits, input int n);
    for (int i = n - 1; i >= 0; i--) begin
      @(posedge mclk);
      si <= bits[i];
      repeat (3) @(posedge mclk);
      sck <= 1'b1;
      repeat (4) @(posedge mclk);
      rx = {rx[6:0], so};
      sck <= 1'b0;
    end
  endtask : shift
  // Chip select stays low for the whole sequence and rises after the last bit.
  task automatic frame(input logic [47:0] bits, input int n);
    @(posedge mclk);
    ce_n <= 1'b0;
    shift(bits, n);
    repeat (4) @(posedge mclk);
    ce_n <= 1'b1;
    si <= ~si;
    repeat (8) @(posedge mclk);
  endtask : frame
endmodule : spi_host_model

// [tb/flash_status_protect_hold_tb_top.sv]
`timescale 1ns/1ns
module flash_status_protect_hold_tb_top;
  localparam logic [7:0] op_we = flash_status_pkg::OP_WRITE_ENABLE;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic wp_n = 1'b1;
  logic op_done = 1'b0;
  logic sck, ce_n, si, so, so_oe, rst_hold_n, op_valid, array_abort, hold_active, hold_mode;
  logic [7:0] status_and_protection;
  flash_status_pkg::op_request_type op_request, req;
  logic seen = 1'b0;
  logic [19:0] a;
  logic [19:0] edges [8] = '{20'hf0000, 20'hefffe, 20'he0000, 20'hdffff, 20'hc0000, 20'hbffff, 20'h80000, 20'h7ffff};
  logic [7:0] kinds [4] = '{8'h02, 8'h20, 8'h52, 8'hd8};
  int n_fail = 0;
  int check_count = 0;
  int seed = 84;
  always #25 mclk = ~mclk;
  flash_status_protect_hold i_flash_status_protect_hold (.mclk, .reset, .sck, .ce_n, .si, .so, .so_oe, .wp_n,
    .rst_hold_n, .op_request, .op_valid, .op_done, .array_abort, .status_and_protection, .hold_active, .hold_mode);
  spi_host_model i_host (.mclk, .sck, .ce_n, .si, .so, .hold_n(rst_hold_n));
  always @(posedge mclk) begin
    if (op_valid === 1'b1) begin
      seen <= 1'b1;
      req <= op_request;
    end
  end
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic cmd(input logic [7:0] op);
    i_host.frame({40'h0, op}, 8);
  endtask : cmd
  task automatic status_write_cmd(input logic [7:0] v, input logic [7:0] en);
    cmd(en);
    i_host.frame({32'h0, flash_status_pkg::OP_STATUS_WRITE, v}, 16);
  endtask : status_write_cmd
  function automatic logic prot_ok(input logic [2:0] lv, input logic [19:0] addr);
    case (lv)
      3'h0: return 1'b1;
      3'h1: return addr < 20'hf0000;
      3'h2: return addr < 20'he0000;
      3'h3: return addr < 20'hc0000;
      3'h4: return addr < 20'h80000;
      default: return 1'b0;
    endcase
  endfunction : prot_ok
  // The array side answers each operation accepted within prog; only status reads go out while busy.
  task automatic prog(input logic [7:0] op, input logic [19:0] addr, input int n, input logic acc, input logic we);
    if (we) cmd(op_we);
    seen = 1'b0;
    i_host.frame({op, 4'h0, addr, 16'ha5c3} >> (48 - n), n);
    check(seen, acc);
    if (seen === 1'b1) begin
      if (n > 8) check(req.addr[19:0], addr);
      else check(req.kind, flash_status_pkg::KIND_CHIP_ERASE);
      check({status_and_protection[6], status_and_protection[0]}, {op == 8'had, 1'b1});
      op_done <= 1'b1;
      @(posedge mclk);
      op_done <= 1'b0;
      repeat (2) @(posedge mclk);
      check({status_and_protection[6], status_and_protection[1:0]}, 3'h0);
    end
  endtask : prog
  initial begin
    repeat (80000) @(posedge mclk);
    n_fail++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check(status_and_protection, flash_status_pkg::STATUS_RESET);
    cmd(op_we);
    i_host.frame({32'h0, flash_status_pkg::OP_READ_STATUS, 8'h00}, 16);
    check(i_host.rx, 8'h1e);
    cmd(flash_status_pkg::OP_WRITE_DISABLE);
    check(status_and_protection, 8'h1c);
    prog(8'h02, 20'h00010, 40, 1'b0, 1'b0);
    status_write_cmd(8'h80, op_we);
    check(status_and_protection, 8'h80);
    wp_n <= 1'b0;
    status_write_cmd(8'h00, op_we);
    check(status_and_protection, 8'h80);
    wp_n <= 1'b1;
    status_write_cmd(8'h00, flash_status_pkg::OP_STATUS_WRITE_ENABLE);
    check(status_and_protection, 8'h00);
    $display("lock test done");
    for (int lv = 0; lv < 9; lv++) begin
      status_write_cmd(8'(lv << 2), op_we);
      check(status_and_protection, 8'(lv << 2));
      for (int k = 0; k < 9; k++) begin
        a = (k < 8) ? edges[k] : 20'($random(seed));
        prog(kinds[k % 4], a, (k % 4 == 0) ? 40 : 32, prot_ok(3'(lv), a), 1'b1);
      end
      prog(lv[0] ? 8'hc7 : 8'h60, 20'h0, 8, lv == 0, 1'b1);
    end
    $display("protection test done");
    status_write_cmd(8'h00, op_we);
    prog(8'had, 20'hffffe, 48, 1'b1, 1'b1);
    cmd(op_we);
    i_host.frame({8'h02, 24'h000100, 8'h3c}, 40);
    i_host.frame({32'h0, flash_status_pkg::OP_READ_STATUS, 8'h00}, 16);
    check(i_host.rx[0], 1'b1);
    i_host.hold_n <= 1'b0;
    repeat (flash_status_pkg::PROGRAM_RESET_MIN_NS / 50 + 1) @(posedge mclk);
    check(array_abort, 1'b1);
    i_host.hold_n <= 1'b1;
    repeat (6) @(posedge mclk);
    check(status_and_protection, flash_status_pkg::STATUS_RESET);
    $display("reset test done");
    cmd(flash_status_pkg::OP_PAUSE_ENABLE);
    check(hold_mode, 1'b1);
    i_host.ce_n <= 1'b0;
    i_host.shift(48'h0, 3);
    @(posedge mclk);
    i_host.si <= 1'b0;
    repeat (3) @(posedge mclk);
    i_host.sck <= 1'b1;
    i_host.hold_n <= 1'b0;
    repeat (3) @(posedge mclk);
    check(hold_active, 1'b0);
    i_host.sck <= 1'b0;
    repeat (6) @(posedge mclk);
    check({hold_active, so_oe}, 2'b10);
    i_host.shift($random(seed), 3);
    @(posedge mclk);
    i_host.sck <= 1'b1;
    i_host.hold_n <= 1'b1;
    repeat (3) @(posedge mclk);
    check(hold_active, 1'b1);
    i_host.sck <= 1'b0;
    repeat (6) @(posedge mclk);
    check(hold_active, 1'b0);
    i_host.shift(48'h500, 12);
    check(i_host.rx, flash_status_pkg::STATUS_RESET);
    i_host.ce_n <= 1'b1;
    i_host.frame({40'h0, op_we}, 8);
    check(status_and_protection[1], 1'b1);
    cmd(flash_status_pkg::OP_WRITE_DISABLE);
    i_host.ce_n <= 1'b0;
    i_host.shift({40'h0, op_we}, 8);
    i_host.hold_n <= 1'b0;
    repeat (6) @(posedge mclk);
    check(hold_active, 1'b1);
    i_host.ce_n <= 1'b1;
    repeat (8) @(posedge mclk);
    check({hold_active, status_and_protection[1], array_abort}, 3'h0);
    i_host.hold_n <= 1'b1;
    $display("hold test done");
    reset <= 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (4) @(posedge mclk);
    check({hold_mode, status_and_protection}, {1'b0, flash_status_pkg::STATUS_RESET});
    $display("power-up test done");
    end_sim();
  end
endmodule : flash_status_protect_hold_tb_top
